// ---- serial_break_sync_tx.sv ----
// serial port transmitter with break/sync header, break detection and
// synchronous host transmit; async receiver only for break/wake detection.
// assumes a single-cycle register port and two-way pins resolved outside.
//
// Summary of operation
// - transmit_enable+break request: next write sends break
// - break request self-clears, then queued byte goes
// - holding-empty flag whenever holding register free
// - break seen: ready, framing error, data 00h
// - wake arm: edge sets char-ready flag, then next byte
// - sync mode half duplex on one line
// - sync mode shifts data bits only
// - sync host tx: sync, host, enable, no rx
// - host drives clock pin, driver auto-enabled
// - exactly one clock per data bit
// - polarity bit sets idle level, data edge
// - sync host tx enables data and clock drivers
// - new byte waits while shifter busy
// - empty shifter loads at once, shifts immediately
// - data changes on leading clock edge
// - shift register not software visible
// - ninth bit loaded before low byte
// - tx interrupt needs three enables set
// - break: start, twelve zeros, stop
// - wake arm clears on rising edge
module serial_break_sync_tx
   import serial_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register port
   input wire logic [serial_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // data line pin
   input wire logic data_line_in,
   output logic data_line_out,
   output logic data_line_oe,
   // clock line pin, also async transmit output
   output logic clock_line_out,
   output logic clock_line_oe,
   // interrupt
   output logic tx_irq
);
   import serial_pkg::*;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

   // software registers
   logic [7:0] baud_control_ff, nxt_baud_control;
   logic [7:0] rx_status_control_ff, nxt_rx_status_control;
   logic [7:0] tx_status_control_ff, nxt_tx_status_control;
   logic [7:0] irq_control_ff, nxt_irq_control;
   logic [7:0] baud_divisor_low_ff, nxt_baud_divisor_low;
   logic [7:0] baud_divisor_high_ff, nxt_baud_divisor_high;
   logic [7:0] rdata_ff, nxt_rdata;
   // transmit path
   logic hold_full_ff, nxt_hold_full;
   logic [7:0] hold_data_ff, nxt_hold_data;
   logic hold_ninth_ff, nxt_hold_ninth;
   logic tx_busy_ff, nxt_tx_busy;
   logic tx_is_break_ff, nxt_tx_is_break;
   logic [13:0] tx_shift_reg_ff, nxt_tx_shift_reg;
   logic [3:0] tx_bits_left_ff, nxt_tx_bits_left;
   logic [CNT_W-1:0] tx_tmr_ff, nxt_tx_tmr;
   // pins
   logic data_out_ff, nxt_data_out;
   logic data_oe_ff, nxt_data_oe;
   logic clk_out_ff, nxt_clk_out;
   logic clk_oe_ff, nxt_clk_oe;
   // receive path
   logic din_meta_ff, din_ff, din_prev_ff;
   rx_state_e rx_state_ff, nxt_rx_state;
   logic [CNT_W-1:0] rx_tmr_ff, nxt_rx_tmr;
   logic [2:0] rx_cnt_ff, nxt_rx_cnt;
   logic [7:0] rx_shift_ff, nxt_rx_shift;
   logic [7:0] rx_data_out_ff, nxt_rx_data_out;
   logic framing_error_flag_ff, nxt_framing_error_flag;
   logic rx_char_ready_flag_ff, nxt_rx_char_ready_flag;

   // decoded fields
   logic port_enable, sync_mode, host_clock_source, transmit_enable;
   logic send_break_request, nine_bit_tx_select, clock_idle_polarity;
   logic single_receive_arm, continuous_receive_arm, wake_on_edge_arm;
   logic tx_holding_empty_flag, rx_armed, host_tx_mode, tx_allowed;
   logic wr_holding, rd_rx_data, break_done, din_fall, din_rise;
   logic [CNT_W-1:0] divisor, prescale, bit_cycles;

   assign port_enable = rx_status_control_ff[RS_PORT_ENABLE];
   assign single_receive_arm = rx_status_control_ff[RS_SINGLE_RECEIVE_ARM];
   assign continuous_receive_arm =
      rx_status_control_ff[RS_CONTINUOUS_RECEIVE_ARM];
   assign sync_mode = tx_status_control_ff[TS_SYNC_MODE];
   assign host_clock_source = tx_status_control_ff[TS_HOST_CLOCK_SOURCE];
   assign transmit_enable = tx_status_control_ff[TS_TRANSMIT_ENABLE];
   assign send_break_request = tx_status_control_ff[TS_SEND_BREAK_REQUEST];
   assign nine_bit_tx_select = tx_status_control_ff[TS_NINE_BIT_TX_SELECT];
   assign clock_idle_polarity = baud_control_ff[BC_CLOCK_IDLE_POLARITY];
   assign wake_on_edge_arm = baud_control_ff[BC_WAKE_ON_EDGE_ARM];

   assign rx_armed = single_receive_arm | continuous_receive_arm;
   assign host_tx_mode = sync_mode & host_clock_source & ~rx_armed;
   // client mode and sync receive are outside this block
   assign tx_allowed = port_enable & transmit_enable &
                       (~sync_mode | host_tx_mode);
   assign tx_holding_empty_flag = ~hold_full_ff;
   assign wr_holding = reg_wr & (reg_addr == OFF_TX_DATA_HOLDING);
   assign rd_rx_data = reg_rd & (reg_addr == OFF_RX_DATA_OUT);
   assign din_fall = din_prev_ff & ~din_ff;
   assign din_rise = ~din_prev_ff & din_ff;
   assign break_done = tx_busy_ff & tx_is_break_ff &
                       (tx_tmr_ff == '0) & (tx_bits_left_ff == 4'h1);

   // bit period: sync host always uses the fast prescale
   always_comb begin
      divisor = {8'h00, baud_divisor_high_ff, baud_divisor_low_ff};
      if (!baud_control_ff[BC_BAUD_WIDE_COUNTER]) begin
         divisor = {16'h0000, baud_divisor_low_ff};
      end
      if (sync_mode || (baud_control_ff[BC_BAUD_WIDE_COUNTER] &&
          tx_status_control_ff[TS_BAUD_HIGH_SPEED])) begin
         prescale = CNT_W'(PRESCALE_FAST);
      end else if (baud_control_ff[BC_BAUD_WIDE_COUNTER] ||
                   tx_status_control_ff[TS_BAUD_HIGH_SPEED]) begin
         prescale = CNT_W'(PRESCALE_MID);
      end else begin
         prescale = CNT_W'(PRESCALE_SLOW);
      end
      bit_cycles = CNT_W'(prescale * (divisor + 1'b1));
   end

   // register file
   always_comb begin
      nxt_baud_control = baud_control_ff;
      nxt_rx_status_control = rx_status_control_ff;
      nxt_tx_status_control = tx_status_control_ff;
      nxt_irq_control = irq_control_ff;
      nxt_baud_divisor_low = baud_divisor_low_ff;
      nxt_baud_divisor_high = baud_divisor_high_ff;
      nxt_rdata = 8'h00;
      // hardware clears first so a same-cycle software set wins
      if (break_done) begin
         nxt_tx_status_control[TS_SEND_BREAK_REQUEST] = 1'b0;
      end
      if (wake_on_edge_arm && din_rise) begin
         nxt_baud_control[BC_WAKE_ON_EDGE_ARM] = 1'b0;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            OFF_BAUD_CONTROL: begin
               nxt_baud_control[BC_CLOCK_IDLE_POLARITY] =
                  reg_wdata[BC_CLOCK_IDLE_POLARITY];
               nxt_baud_control[BC_BAUD_WIDE_COUNTER] =
                  reg_wdata[BC_BAUD_WIDE_COUNTER];
               nxt_baud_control[BC_AUTOBAUD_ARM] =
                  reg_wdata[BC_AUTOBAUD_ARM];
               if (reg_wdata[BC_WAKE_ON_EDGE_ARM] || !din_rise) begin
                  nxt_baud_control[BC_WAKE_ON_EDGE_ARM] =
                     reg_wdata[BC_WAKE_ON_EDGE_ARM];
               end
            end
            OFF_RX_STATUS_CONTROL: begin
               nxt_rx_status_control = reg_wdata & 8'hf8;
            end
            OFF_TX_STATUS_CONTROL: begin
               nxt_tx_status_control = reg_wdata & 8'hfd;
            end
            OFF_IRQ_CONTROL: nxt_irq_control = reg_wdata & 8'hd0;
            OFF_BAUD_DIVISOR_LOW: nxt_baud_divisor_low = reg_wdata;
            OFF_BAUD_DIVISOR_HIGH: nxt_baud_divisor_high = reg_wdata;
            default: ;
         endcase
      end
      // the shift register has no address and never reads back
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_BAUD_CONTROL: begin
               nxt_rdata = baud_control_ff;
               nxt_rdata[BC_RX_IDLE] = (rx_state_ff == RX_IDLE);
            end
            OFF_RX_STATUS_CONTROL: begin
               nxt_rdata = rx_status_control_ff;
               nxt_rdata[RS_FRAMING_ERROR_FLAG] = framing_error_flag_ff;
            end
            OFF_TX_STATUS_CONTROL: begin
               nxt_rdata = tx_status_control_ff;
               nxt_rdata[TS_SHIFTER_IDLE] = ~tx_busy_ff;
            end
            OFF_IRQ_CONTROL: begin
               nxt_rdata = irq_control_ff;
               nxt_rdata[IC_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
               nxt_rdata[IC_RX_CHAR_READY_FLAG] = rx_char_ready_flag_ff;
            end
            OFF_BAUD_DIVISOR_LOW: nxt_rdata = baud_divisor_low_ff;
            OFF_BAUD_DIVISOR_HIGH: nxt_rdata = baud_divisor_high_ff;
            OFF_RX_DATA_OUT: nxt_rdata = rx_data_out_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // transmit holding register and shifter
   always_comb begin
      nxt_hold_full = hold_full_ff;
      nxt_hold_data = hold_data_ff;
      nxt_hold_ninth = hold_ninth_ff;
      nxt_tx_busy = tx_busy_ff;
      nxt_tx_is_break = tx_is_break_ff;
      nxt_tx_shift_reg = tx_shift_reg_ff;
      nxt_tx_bits_left = tx_bits_left_ff;
      nxt_tx_tmr = tx_tmr_ff;
      if (tx_busy_ff) begin
         if (tx_tmr_ff != '0) begin
            nxt_tx_tmr = tx_tmr_ff - 1'b1;
         end else if (tx_bits_left_ff == 4'h1) begin
            nxt_tx_busy = 1'b0;
            nxt_tx_is_break = 1'b0;
         end else begin
            nxt_tx_shift_reg = {1'b1, tx_shift_reg_ff[13:1]};
            nxt_tx_bits_left = tx_bits_left_ff - 1'b1;
            nxt_tx_tmr = bit_cycles - 1'b1;
         end
      end else if (hold_full_ff && tx_allowed) begin
         // empty shifter takes the byte at once
         nxt_hold_full = 1'b0;
         nxt_tx_busy = 1'b1;
         nxt_tx_tmr = bit_cycles - 1'b1;
         nxt_tx_is_break = 1'b0;
         if (sync_mode) begin
            nxt_tx_shift_reg = {5'h00, hold_ninth_ff, hold_data_ff};
            nxt_tx_bits_left = nine_bit_tx_select ?
                               SYNC_BITS_9 : SYNC_BITS_8;
         end else if (send_break_request) begin
            // written value is dropped, start, twelve zeros and a high stop bit go out
            nxt_tx_shift_reg = BREAK_FRAME;
            nxt_tx_bits_left = BREAK_BITS;
            nxt_tx_is_break = 1'b1;
         end else if (nine_bit_tx_select) begin
            nxt_tx_shift_reg = {3'h0, 1'b1, hold_ninth_ff,
                                hold_data_ff, 1'b0};
            nxt_tx_bits_left = ASYNC_BITS_9;
         end else begin
            nxt_tx_shift_reg = {4'h0, 1'b1, hold_data_ff, 1'b0};
            nxt_tx_bits_left = ASYNC_BITS_8;
         end
      end
      // a full holding register ignores further writes
      if (wr_holding && transmit_enable && !hold_full_ff) begin
         nxt_hold_full = 1'b1;
         nxt_hold_data = reg_wdata;
         nxt_hold_ninth = tx_status_control_ff[TS_TX_NINTH_BIT];
      end
      if (!transmit_enable || !port_enable) begin
         nxt_hold_full = 1'b0;
         nxt_tx_busy = 1'b0;
         nxt_tx_is_break = 1'b0;
      end
   end

   // pin drivers, all registered so shifting and clock share one lag
   always_comb begin
      nxt_clk_oe = port_enable & (sync_mode ?
                   host_clock_source & (transmit_enable | rx_armed) :
                   transmit_enable);
      nxt_data_oe = port_enable & transmit_enable & host_tx_mode;
      nxt_data_out = ~sync_mode | ~tx_busy_ff | tx_shift_reg_ff[0];
      if (sync_mode) begin
         // first half of each bit is away from idle: the leading edge
         // starts the bit, so data is stable at the trailing edge
         nxt_clk_out = clock_idle_polarity ^ (tx_busy_ff &
                       (tx_tmr_ff >= (bit_cycles >> 1)));
      end else begin
         nxt_clk_out = tx_busy_ff ? tx_shift_reg_ff[0] : 1'b1;
      end
   end

   // async receiver: break and wake detection
   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_tmr = rx_tmr_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_shift = rx_shift_ff;
      nxt_rx_data_out = rx_data_out_ff;
      nxt_framing_error_flag = framing_error_flag_ff;
      nxt_rx_char_ready_flag = rx_char_ready_flag_ff & ~rd_rx_data;
      if (rx_tmr_ff != '0) begin
         nxt_rx_tmr = rx_tmr_ff - 1'b1;
      end
      unique case (rx_state_ff)
         RX_IDLE: begin
            if (wake_on_edge_arm) begin
               if (din_fall) begin
                  nxt_rx_char_ready_flag = 1'b1;
               end
            end else if (din_fall && port_enable && !sync_mode &&
                         continuous_receive_arm) begin
               nxt_rx_state = RX_START;
               nxt_rx_tmr = bit_cycles >> 1;
            end
         end
         RX_START: begin
            if (rx_tmr_ff == '0) begin
               nxt_rx_state = din_ff ? RX_IDLE : RX_DATA;
               nxt_rx_tmr = bit_cycles - 1'b1;
               nxt_rx_cnt = 3'h0;
            end
         end
         RX_DATA: begin
            if (rx_tmr_ff == '0) begin
               nxt_rx_shift = {din_ff, rx_shift_ff[7:1]};
               nxt_rx_cnt = rx_cnt_ff + 1'b1;
               nxt_rx_tmr = bit_cycles - 1'b1;
               if (rx_cnt_ff == RX_LAST_BIT) begin
                  nxt_rx_state = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rx_tmr_ff == '0) begin
               // a break lands here as 00h with a low stop bit
               nxt_rx_data_out = rx_shift_ff;
               nxt_framing_error_flag = ~din_ff;
               nxt_rx_char_ready_flag = 1'b1;
               nxt_rx_state = RX_IDLE;
            end
         end
      endcase
      if (!port_enable) begin
         nxt_rx_state = RX_IDLE;
      end
   end

   // sole interrupt path, gated by all three enables
   assign tx_irq = tx_holding_empty_flag &
                   irq_control_ff[IC_TX_IRQ_ENABLE] &
                   irq_control_ff[IC_PERIPHERAL_IRQ_ENABLE] &
                   irq_control_ff[IC_GLOBAL_IRQ_ENABLE];
   assign reg_rdata = rdata_ff;
   assign data_line_out = data_out_ff;
   assign data_line_oe = data_oe_ff;
   assign clock_line_out = clk_out_ff;
   assign clock_line_oe = clk_oe_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         baud_control_ff <= BAUD_CONTROL_RST;
         rx_status_control_ff <= RX_STATUS_CONTROL_RST;
         tx_status_control_ff <= TX_STATUS_CONTROL_RST;
         irq_control_ff <= IRQ_CONTROL_RST;
         baud_divisor_low_ff <= DIVISOR_RST;
         baud_divisor_high_ff <= DIVISOR_RST;
         rdata_ff <= 8'h00;
         hold_full_ff <= 1'b0;
         hold_data_ff <= 8'h00;
         hold_ninth_ff <= 1'b0;
         tx_busy_ff <= 1'b0;
         tx_is_break_ff <= 1'b0;
         tx_shift_reg_ff <= 14'h3fff;
         tx_bits_left_ff <= 4'h0;
         tx_tmr_ff <= '0;
         data_out_ff <= 1'b1;
         data_oe_ff <= 1'b0;
         clk_out_ff <= 1'b1;
         clk_oe_ff <= 1'b0;
         din_meta_ff <= 1'b1;
         din_ff <= 1'b1;
         din_prev_ff <= 1'b1;
         rx_state_ff <= RX_IDLE;
         rx_tmr_ff <= '0;
         rx_cnt_ff <= 3'h0;
         rx_shift_ff <= 8'h00;
         rx_data_out_ff <= 8'h00;
         framing_error_flag_ff <= 1'b0;
         rx_char_ready_flag_ff <= 1'b0;
      end else begin
         baud_control_ff <= nxt_baud_control;
         rx_status_control_ff <= nxt_rx_status_control;
         tx_status_control_ff <= nxt_tx_status_control;
         irq_control_ff <= nxt_irq_control;
         baud_divisor_low_ff <= nxt_baud_divisor_low;
         baud_divisor_high_ff <= nxt_baud_divisor_high;
         rdata_ff <= nxt_rdata;
         hold_full_ff <= nxt_hold_full;
         hold_data_ff <= nxt_hold_data;
         hold_ninth_ff <= nxt_hold_ninth;
         tx_busy_ff <= nxt_tx_busy;
         tx_is_break_ff <= nxt_tx_is_break;
         tx_shift_reg_ff <= nxt_tx_shift_reg;
         tx_bits_left_ff <= nxt_tx_bits_left;
         tx_tmr_ff <= nxt_tx_tmr;
         data_out_ff <= nxt_data_out;
         data_oe_ff <= nxt_data_oe;
         clk_out_ff <= nxt_clk_out;
         clk_oe_ff <= nxt_clk_oe;
         din_meta_ff <= data_line_in;
         din_ff <= din_meta_ff;
         din_prev_ff <= din_ff;
         rx_state_ff <= nxt_rx_state;
         rx_tmr_ff <= nxt_rx_tmr;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_shift_ff <= nxt_rx_shift;
         rx_data_out_ff <= nxt_rx_data_out;
         framing_error_flag_ff <= nxt_framing_error_flag;
         rx_char_ready_flag_ff <= nxt_rx_char_ready_flag;
      end
   end

endmodule // serial_break_sync_tx

// ---- serial_break_sync_tx_monitor.sv ----
// port checker for the serial break/sync transmitter
// assumes one sys_clk domain and rst_b active low
module serial_break_sync_tx_monitor
   import serial_pkg::*;
(
   // clock, reset and register port
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [serial_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins and interrupt
   input wire logic data_line_out,
   input wire logic data_line_oe,
   input wire logic clock_line_out,
   input wire logic clock_line_oe,
   input wire logic tx_irq
);
   logic irq_en_ff;
   logic nxt_irq_en;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // shadow of the three interrupt enables
   always_comb begin
      nxt_irq_en = irq_en_ff;
      if (reg_wr && reg_addr == OFF_IRQ_CONTROL)
         nxt_irq_en = reg_wdata[IC_TX_IRQ_ENABLE] &
            reg_wdata[IC_PERIPHERAL_IRQ_ENABLE] &
            reg_wdata[IC_GLOBAL_IRQ_ENABLE];
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) irq_en_ff <= 1'b0;
      else irq_en_ff <= nxt_irq_en;
   end
   sequence rx_arm_wr;
      reg_wr && reg_addr == OFF_RX_STATUS_CONTROL &&
         (reg_wdata[RS_SINGLE_RECEIVE_ARM] ||
         reg_wdata[RS_CONTINUOUS_RECEIVE_ARM]);
   endsequence
   sequence holding_rd;
      reg_rd && reg_addr == OFF_TX_DATA_HOLDING;
   endsequence
   a_rdata_rests_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   a_holding_reads_zero: assert property (holding_rd |=>
      reg_rdata == 8'h00)
      else $error("transmit path readable");
   a_data_needs_clock: assert property (data_line_oe |-> clock_line_oe)
      else $error("data driven without clock driver");
   a_idle_data_high: assert property (!data_line_oe |-> data_line_out)
      else $error("data output low while not driving");
   a_rx_arm_stops: assert property (rx_arm_wr |-> ##[1:3] !data_line_oe)
      else $error("data driver on with receive armed");
   a_irq_needs_enables: assert property (tx_irq |-> irq_en_ff)
      else $error("transmit interrupt without all enables");
   a_oe_rise_idle: assert property ($rose(data_line_oe) |->
      data_line_out && clock_line_oe)
      else $error("drivers enabled in bad state");
   a_clock_half_min: assert property (data_line_oe &&
      $changed(clock_line_out) |=> $stable(clock_line_out))
      else $error("shift clock phase shorter than two cycles");
endmodule // serial_break_sync_tx_monitor
bind serial_break_sync_tx serial_break_sync_tx_monitor
   serial_break_sync_tx_monitor_inst (
   .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .data_line_out(data_line_out), .data_line_oe(data_line_oe),
   .clock_line_out(clock_line_out), .clock_line_oe(clock_line_oe),
   .tx_irq(tx_irq));

// ---- serial_break_sync_tx_test.sv ----
// bench for the serial break/sync and synchronous host transmitter
// assumes the client model and the bound port checker are compiled first
module serial_break_sync_tx_test import serial_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic line_drv = 1, clr = 0, pol = 0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
   logic data_line_in, data_line_out, data_line_oe;
   logic clock_line_out, clock_line_oe, tx_irq;
   logic [15:0] shift_q;
   int edges, fail_count, total_checks, cyc, n, run, last_run;
   // released line is pulled up
   assign data_line_in = data_line_oe ? data_line_out : line_drv;
   serial_break_sync_tx serial_break_sync_tx_inst (.sys_clk(sys_clk),
      .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .data_line_in(data_line_in), .data_line_out(data_line_out),
      .data_line_oe(data_line_oe), .clock_line_out(clock_line_out),
      .clock_line_oe(clock_line_oe), .tx_irq(tx_irq));
   sync_client_model sync_client_model_inst (.clk_line(clock_line_out),
      .data_line(data_line_in), .idle_pol(pol), .clr(clr),
      .shift_q(shift_q), .edges(edges));
   initial forever #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (clock_line_out === 1'b0) run++;
      else if (run != 0) begin
         last_run = run;
         run = 0;
      end
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   task automatic results();
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1; // settle before checks
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task automatic wait_edges(input int k);
      n = 0;
      while (edges < k && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   // four cycles a bit
   task automatic t_break_sync();
      wr(OFF_BAUD_CONTROL, 8'h08);
      wr(OFF_RX_STATUS_CONTROL, 8'h80);
      wr(OFF_TX_STATUS_CONTROL, 8'h2c);
      wr(OFF_TX_DATA_HOLDING, 8'hff);
      rd(OFF_IRQ_CONTROL);
      chk("holding empty", 16'h0001, 16'(rd_val[0]));
      wr(OFF_TX_DATA_HOLDING, 8'h55);
      rd(OFF_IRQ_CONTROL);
      chk("holding waits", 16'h0000, 16'(rd_val[0]));
      rd(OFF_TX_DATA_HOLDING);
      chk("no readback", 16'h0000, 16'(rd_val));
      n = 0;
      do begin
         rd(OFF_TX_STATUS_CONTROL);
         n++;
      end while (rd_val[TS_SEND_BREAK_REQUEST] && n < 100);
      chk("break request", 16'h0000, 16'(rd_val[TS_SEND_BREAK_REQUEST]));
      chk("break low run", 16'h0034, 16'(last_run));
      repeat (60) @(posedge sys_clk);
      chk("sync low run", 16'h0004, 16'(last_run));
   endtask
   // eight cycles a bit: divisor 1
   task automatic t_sync_tx(input logic p);
      pol = p;
      wr(OFF_BAUD_CONTROL, {3'h0, p, 4'h0});
      wr(OFF_BAUD_DIVISOR_LOW, 8'h01);
      wr(OFF_RX_STATUS_CONTROL, 8'h80);
      wr(OFF_TX_STATUS_CONTROL, 8'hb0);
      repeat (4) @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      chk("clock idle", 16'(p), 16'(clock_line_out));
      chk("drivers", 16'h0003, 16'({data_line_oe, clock_line_oe}));
      wr(OFF_TX_DATA_HOLDING, 8'ha5);
      wr(OFF_TX_DATA_HOLDING, 8'h3c);
      wait_edges(1);
      wait_edges(8);
      chk("bit period", 16'h0038, 16'(n));
      wait_edges(16);
      repeat (20) @(posedge sys_clk);
      chk("clock count", 16'h0010, 16'(edges));
      chk("shifted data", 16'h3ca5, shift_q);
      wr(OFF_IRQ_CONTROL, 8'hd0);
      chk("irq on", 16'h0001, 16'(tx_irq));
      wr(OFF_IRQ_CONTROL, 8'h50);
      chk("irq off", 16'h0000, 16'(tx_irq));
      wr(OFF_RX_STATUS_CONTROL, 8'h90);
      repeat (3) @(posedge sys_clk);
      chk("rx arm", 16'h0001, 16'({data_line_oe, clock_line_oe}));
   endtask
   task automatic t_break_rx();
      wr(OFF_BAUD_CONTROL, 8'h08);
      wr(OFF_BAUD_DIVISOR_LOW, 8'h00);
      wr(OFF_TX_STATUS_CONTROL, 8'h04);
      wr(OFF_RX_STATUS_CONTROL, 8'h90);
      line_drv <= 1'b0;
      repeat (56) @(posedge sys_clk);
      line_drv <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rd(OFF_IRQ_CONTROL);
      chk("rx ready", 16'h0001, 16'(rd_val[IC_RX_CHAR_READY_FLAG]));
      rd(OFF_RX_STATUS_CONTROL);
      chk("framing", 16'h0001, 16'(rd_val[RS_FRAMING_ERROR_FLAG]));
      rd(OFF_RX_DATA_OUT);
      chk("rx data", 16'h0000, 16'(rd_val));
      wr(OFF_BAUD_CONTROL, 8'h0b);
      line_drv <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rd(OFF_IRQ_CONTROL);
      chk("wake ready", 16'h0001, 16'(rd_val[IC_RX_CHAR_READY_FLAG]));
      line_drv <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rd(OFF_BAUD_CONTROL);
      chk("wake arm", 16'h0000, 16'(rd_val[BC_WAKE_ON_EDGE_ARM]));
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_break_sync();
      t_sync_tx(1'b0);
      t_sync_tx(1'b1);
      t_break_rx();
      results();
   end
endmodule // serial_break_sync_tx_test

// ---- serial_pkg.sv ----
// constants for the serial break/sync and synchronous host transmit block
// assumes a byte-wide register port with a 3-bit register index
package serial_pkg;

   localparam int ADDR_W = 3;
   localparam int CNT_W = 24;

   // register index on the plain register port
   localparam logic [2:0] OFF_BAUD_CONTROL = 3'h0;
   localparam logic [2:0] OFF_RX_STATUS_CONTROL = 3'h1;
   localparam logic [2:0] OFF_BAUD_DIVISOR_LOW = 3'h2;
   localparam logic [2:0] OFF_BAUD_DIVISOR_HIGH = 3'h3;
   localparam logic [2:0] OFF_TX_DATA_HOLDING = 3'h4;
   localparam logic [2:0] OFF_TX_STATUS_CONTROL = 3'h5;
   localparam logic [2:0] OFF_RX_DATA_OUT = 3'h6;
   localparam logic [2:0] OFF_IRQ_CONTROL = 3'h7;

   // baud_control fields
   localparam int BC_RX_IDLE = 6;
   localparam int BC_CLOCK_IDLE_POLARITY = 4;
   localparam int BC_BAUD_WIDE_COUNTER = 3;
   localparam int BC_WAKE_ON_EDGE_ARM = 1;
   localparam int BC_AUTOBAUD_ARM = 0;

   // rx_status_control fields
   localparam int RS_PORT_ENABLE = 7;
   localparam int RS_NINE_BIT_RX_SELECT = 6;
   localparam int RS_SINGLE_RECEIVE_ARM = 5;
   localparam int RS_CONTINUOUS_RECEIVE_ARM = 4;
   localparam int RS_ADDRESS_DETECT = 3;
   localparam int RS_FRAMING_ERROR_FLAG = 2;

   // tx_status_control fields
   localparam int TS_HOST_CLOCK_SOURCE = 7;
   localparam int TS_NINE_BIT_TX_SELECT = 6;
   localparam int TS_TRANSMIT_ENABLE = 5;
   localparam int TS_SYNC_MODE = 4;
   localparam int TS_SEND_BREAK_REQUEST = 3;
   localparam int TS_BAUD_HIGH_SPEED = 2;
   localparam int TS_SHIFTER_IDLE = 1;
   localparam int TS_TX_NINTH_BIT = 0;

   // irq_control fields
   localparam int IC_TX_HOLDING_EMPTY_FLAG = 0;
   localparam int IC_RX_CHAR_READY_FLAG = 1;
   localparam int IC_TX_IRQ_ENABLE = 4;
   localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int IC_GLOBAL_IRQ_ENABLE = 7;

   // reset values
   localparam logic [7:0] BAUD_CONTROL_RST = 8'h00;
   localparam logic [7:0] RX_STATUS_CONTROL_RST = 8'h00;
   localparam logic [7:0] TX_STATUS_CONTROL_RST = 8'h00;
   localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
   localparam logic [7:0] DIVISOR_RST = 8'h00;

   // sys_clk cycles per divisor step
   localparam int PRESCALE_SLOW = 64;
   localparam int PRESCALE_MID = 16;
   localparam int PRESCALE_FAST = 4;

   // bits per shifted character, frame bits included
   localparam logic [3:0] BREAK_BITS = 4'he;
   localparam logic [3:0] ASYNC_BITS_8 = 4'ha;
   localparam logic [3:0] ASYNC_BITS_9 = 4'hb;
   localparam logic [3:0] SYNC_BITS_8 = 4'h8;
   localparam logic [3:0] SYNC_BITS_9 = 4'h9;
   localparam logic [13:0] BREAK_FRAME = 14'h2000;
   localparam logic [2:0] RX_LAST_BIT = 3'h7;

endpackage

// ---- sync_client_model.sv ----
// synchronous client receiver on the host clock and data lines
// assumes the bench resolves the data line and gives the idle level
module sync_client_model (
   // pins
   input wire logic clk_line,
   input wire logic data_line,
   // setup
   input wire logic idle_pol,
   input wire logic clr,
   // capture
   output logic [15:0] shift_q,
   output int edges
);
   timeunit 1ns;
   timeprecision 100ps;
   // samples on the trailing edge, the return to idle
   always @(clk_line or posedge clr) begin
      if (clr) begin
         shift_q = 16'h0000;
         edges = 0;
      end else if (clk_line === idle_pol) begin
         shift_q = {data_line, shift_q[15:1]};
         edges = edges + 1;
      end
   end
endmodule // sync_client_model
